// file: design/cmbf_buffer.sv
// can message buffer image packer and unpacker over dma ram
`include "cmbf_params.svh"

module cmbf_buffer #(
  parameter int ADDR_W = 16,
  parameter int BUF_W  = 5
) (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_b_i,
  // configuration
  input  wire logic [ADDR_W-1:0]       base_addr_i,
  // store request, receive or transmit buffer
  input  wire logic                    store_req_i,
  input  wire logic [BUF_W-1:0]        store_buf_i,
  input  wire logic                    buffer_direction_sel_i,
  input  wire logic [4:0]              filter_match_index_i,
  input  wire cmbf_pkg::cmbf_frame_type store_frame_i,
  // transmit fetch request
  input  wire logic                    fetch_req_i,
  input  wire logic [BUF_W-1:0]        fetch_buf_i,
  output logic                         fetch_done_o,
  output cmbf_pkg::cmbf_frame_type     fetch_frame_o,
  output logic                         busy_o,
  // dma ram port, read data valid one cycle after request
  output logic                         ram_req_o,
  output logic                         ram_we_o,
  output logic [ADDR_W-1:0]            ram_addr_o,
  output logic [15:0]                  ram_wdata_o,
  input  wire logic [15:0]             ram_rdata_i
);
  import cmbf_pkg::*;

  cmbf_state_type state_q, state_d;
  logic [3:0]        idx_q, idx_d;
  logic [ADDR_W-1:0] bufa_q, bufa_d;
  logic              rx_q, rx_d;
  logic [4:0]        fhit_q, fhit_d;
  cmbf_frame_type    frm_q, frm_d;
  logic              done_q, done_d;
  logic              req_q, req_d;
  logic              we_q, we_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [15:0]       wd_q, wd_d;
  logic              busy_q, busy_d;

  // start address of buffer n
  function automatic logic [ADDR_W-1:0] buf_base(input logic [ADDR_W-1:0] b,
                                                 input logic [BUF_W-1:0] n);
    buf_base = b + ADDR_W'({n, 3'h0});
  endfunction

  // pack one word of the image
  function automatic logic [15:0] pack_word(input logic [2:0] w, input cmbf_frame_type f,
                                            input logic [4:0] fh);
    pack_word = 16'h0000;
    case (w)
      3'h0: pack_word = {3'h0, f.std_ident, f.srr, f.ide};
      3'h1: pack_word = {4'h0, f.ext_ident[17:6]};
      3'h2: pack_word = {f.ext_ident[5:0], f.rtr, 1'b0, 3'h0, 1'b0, f.dlc};
      3'h3: pack_word = {f.data[15:8], f.data[7:0]};
      3'h4: pack_word = {f.data[31:24], f.data[23:16]};
      3'h5: pack_word = {f.data[47:40], f.data[39:32]};
      3'h6: pack_word = {f.data[63:56], f.data[55:48]};
      3'h7: pack_word = {3'h0, fh, 8'h00};
      default: pack_word = 16'h0000;
    endcase
  endfunction

  // fold one read word into the frame
  function automatic cmbf_frame_type unpack_word(input logic [2:0] w, input logic [15:0] d,
                                                 input cmbf_frame_type f);
    cmbf_frame_type r;
    r = f;
    case (w)
      3'h0: {r.std_ident, r.srr, r.ide} = d[12:0];
      3'h1: r.ext_ident[17:6] = d[11:0];
      3'h2: begin
        r.ext_ident[5:0] = d[15:10];
        r.rtr            = d[9];
        r.dlc            = d[3:0];
      end
      3'h3: r.data[15:0]  = d;
      3'h4: r.data[31:16] = d;
      3'h5: r.data[47:32] = d;
      3'h6: r.data[63:48] = d;
      default: r = f;
    endcase
    unpack_word = r;
  endfunction

  always_comb begin
    state_d  = state_q;
    idx_d    = idx_q;
    bufa_d   = bufa_q;
    rx_d     = rx_q;
    fhit_d   = fhit_q;
    frm_d    = frm_q;
    done_d   = 1'b0;
    req_d    = 1'b0;
    we_d     = 1'b0;
    addr_d   = addr_q;
    wd_d     = wd_q;
    case (state_q)
      CMBF_IDLE: begin
        idx_d = 4'h0;
        if (store_req_i) begin
          state_d = CMBF_WRITE;
          bufa_d  = buf_base(base_addr_i, store_buf_i);
          rx_d    = (buffer_direction_sel_i != `CMBF_DIR_TX);
          fhit_d  = filter_match_index_i;
          frm_d   = store_frame_i;
        end else if (fetch_req_i) begin
          // word 0 read leaves on the taking edge to hide the ram latency
          state_d = CMBF_READ;
          bufa_d  = buf_base(base_addr_i, fetch_buf_i);
          req_d   = 1'b1;
          addr_d  = buf_base(base_addr_i, fetch_buf_i);
          idx_d   = 4'h1;
        end
      end
      CMBF_WRITE: begin
        // word 7 skipped for transmit buffers
        if (idx_q == 4'h7 && !rx_q) begin
          state_d = CMBF_IDLE;
          done_d  = 1'b1;
        end else begin
          req_d  = 1'b1;
          we_d   = 1'b1;
          addr_d = bufa_q + ADDR_W'(idx_q);
          wd_d   = pack_word(idx_q[2:0], frm_q, fhit_q);
          idx_d  = idx_q + 4'h1;
          if (idx_q == 4'h7) begin
            state_d = CMBF_IDLE;
            done_d  = 1'b1;
          end
        end
      end
      CMBF_READ: begin
        // issue words 1..6, take word idx-2 one cycle after its read
        req_d  = 1'b1;
        addr_d = bufa_q + ADDR_W'(idx_q);
        idx_d  = idx_q + 4'h1;
        if (idx_q >= 4'h2) frm_d = unpack_word(3'(idx_q - 4'h2), ram_rdata_i, frm_q);
        if (idx_q == 4'h6) state_d = CMBF_WAIT;
      end
      CMBF_WAIT: begin
        // drain the data of words 5 and 6
        frm_d = unpack_word(3'(idx_q - 4'h2), ram_rdata_i, frm_q);
        idx_d = idx_q + 4'h1;
        if (idx_q == 4'h8) begin
          done_d  = 1'b1;
          state_d = CMBF_IDLE;
        end
      end
      default: state_d = CMBF_IDLE;
    endcase
    busy_d = (state_d != CMBF_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_q  <= CMBF_IDLE;
      idx_q    <= 4'h0;
      bufa_q   <= '0;
      rx_q     <= 1'b0;
      fhit_q   <= 5'h00;
      frm_q    <= '0;
      done_q   <= 1'b0;
      req_q    <= 1'b0;
      we_q     <= 1'b0;
      addr_q   <= '0;
      wd_q     <= 16'h0000;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      idx_q    <= idx_d;
      bufa_q   <= bufa_d;
      rx_q     <= rx_d;
      fhit_q   <= fhit_d;
      frm_q    <= frm_d;
      done_q   <= done_d;
      req_q    <= req_d;
      we_q     <= we_d;
      addr_q   <= addr_d;
      wd_q     <= wd_d;
      busy_q   <= busy_d;
    end
  end

  assign fetch_done_o  = done_q;
  assign fetch_frame_o = frm_q;
  assign busy_o        = busy_q;
  assign ram_req_o     = req_q;
  assign ram_we_o      = we_q;
  assign ram_addr_o    = addr_q;
  assign ram_wdata_o   = wd_q;

  sequence s_store_start;
    state_q == CMBF_IDLE && store_req_i;
  endsequence
  sequence s_fetch_start;
    state_q == CMBF_IDLE && !store_req_i && fetch_req_i;
  endsequence
  a_zero_bits_w0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ram_we_o && ram_addr_o == bufa_q) |-> ram_wdata_o[15:13] == 3'h0)
    else $error("reserved bits of word 0 written nonzero");
  a_tx_no_w7: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ram_we_o && !rx_q) |-> ram_addr_o != bufa_q + ADDR_W'(7))
    else $error("filter word written for transmit buffer");
  a_fhit_field: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ram_we_o && rx_q && ram_addr_o == bufa_q + ADDR_W'(7))
      |-> ram_wdata_o == {3'h0, fhit_q, 8'h00})
    else $error("filter word malformed");
  a_store_order: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_store_start |=> ##1 (ram_we_o && ram_addr_o == bufa_q)
      ##1 (ram_addr_o == bufa_q + ADDR_W'(1)))
    else $error("store words out of order");
  a_fetch_order: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_fetch_start |=> (ram_req_o && !ram_we_o && ram_addr_o == bufa_q)
      ##1 (ram_req_o && ram_addr_o == bufa_q + ADDR_W'(1)))
    else $error("fetch words out of order");
  a_fetch_time: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_fetch_start |-> ##9 fetch_done_o)
    else $error("fetch not done in nine cycles");
  a_w2_reserved: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ram_we_o && ram_addr_o == bufa_q + ADDR_W'(2)) |-> ram_wdata_o[8:4] == 5'h00)
    else $error("reserved bits of word 2 written nonzero");
  a_w1_reserved: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (ram_we_o && ram_addr_o == bufa_q + ADDR_W'(1)) |-> ram_wdata_o[15:12] == 4'h0)
    else $error("upper bits of word 1 written nonzero");
  a_store_len: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_store_start |-> ##9 done_q)
    else $error("store not done in nine cycles");
endmodule

// file: design/cmbf_params.svh
// constants for the can message buffer packer
`ifndef CMBF_PARAMS_SVH
`define CMBF_PARAMS_SVH
`define CMBF_WORDS_PER_BUF  4'h8
`define CMBF_W0_SID_HI      12
`define CMBF_W0_SID_LO      2
`define CMBF_W0_SRR         1
`define CMBF_W0_IDE         0
`define CMBF_W1_EID_HI      11
`define CMBF_W1_EID_LO      0
`define CMBF_W2_EID_HI      15
`define CMBF_W2_EID_LO      10
`define CMBF_W2_RTR         9
`define CMBF_W2_RB1         8
`define CMBF_W2_RB0         4
`define CMBF_W2_DLC_HI      3
`define CMBF_W2_DLC_LO      0
`define CMBF_W7_FHIT_HI     12
`define CMBF_W7_FHIT_LO     8
`define CMBF_DIR_TX         1'b1
`endif

// file: design/cmbf_pkg.sv
// types for the can message buffer packer
package cmbf_pkg;
  typedef struct packed {
    logic [10:0] std_ident;
    logic        srr;
    logic        ide;
    logic [17:0] ext_ident;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cmbf_frame_type;
  typedef enum logic [1:0] {
    CMBF_IDLE,
    CMBF_WRITE,
    CMBF_READ,
    CMBF_WAIT
  } cmbf_state_type;
endpackage

// file: tb/cmbf_ram_model.sv
// dma ram model holding message buffer images
module cmbf_ram_model (
  // clock
  input  wire logic        core_clk_i,
  // word access port
  input  wire logic        ram_req_i,
  input  wire logic        ram_we_i,
  input  wire logic [15:0] ram_addr_i,
  input  wire logic [15:0] ram_wdata_i,
  output logic      [15:0] ram_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  initial ram_rdata_o = 16'h0000;
  always @(posedge core_clk_i) begin
    if (ram_req_i && ram_we_i) begin
      mem[ram_addr_i] <= ram_wdata_i;
    end
    // read data stands one cycle, then the line toggles
    if (ram_req_i && !ram_we_i) begin
      ram_rdata_o <= mem[ram_addr_i];
    end else begin
      ram_rdata_o <= ~ram_rdata_o;
    end
  end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the can message buffer packer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmbf_pkg::*;
  localparam logic [15:0] BASE   = 16'h0100;
  localparam logic [15:0] BASE_B = 16'h0240;
  logic           clk, rst_b, st_req, ft_req, dir_sel, done, busy, req, we;
  logic [4:0]     st_buf, ft_buf, fhit;
  logic [15:0]    addr, wdata, rdata, base;
  cmbf_frame_type st_frame, ft_frame, f1, f2;
  int             bad_count = 0;
  int             comparisons = 0;

  cmbf_buffer #(.ADDR_W(16), .BUF_W(5)) i_dut (.core_clk_i(clk), .rst_b_i(rst_b),
    .base_addr_i(base), .store_req_i(st_req), .store_buf_i(st_buf),
    .buffer_direction_sel_i(dir_sel), .filter_match_index_i(fhit),
    .store_frame_i(st_frame), .fetch_req_i(ft_req), .fetch_buf_i(ft_buf),
    .fetch_done_o(done), .fetch_frame_o(ft_frame), .busy_o(busy), .ram_req_o(req),
    .ram_we_o(we), .ram_addr_o(addr), .ram_wdata_o(wdata), .ram_rdata_i(rdata));
  cmbf_ram_model i_ram (.core_clk_i(clk), .ram_req_i(req), .ram_we_i(we),
    .ram_addr_i(addr), .ram_wdata_i(wdata), .ram_rdata_o(rdata));

  task automatic chk_word(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_frame(cmbf_frame_type exp, cmbf_frame_type got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] fetched frame expected %h seen %h", exp, got);
    end
  endtask
  // expected image word k of a buffer
  function automatic logic [15:0] img(cmbf_frame_type f, logic [4:0] fh, int k);
    case (k)
      0: return {3'h0, f.std_ident, f.srr, f.ide};
      1: return {4'h0, f.ext_ident[17:6]};
      2: return {f.ext_ident[5:0], f.rtr, 1'b0, 3'h0, 1'b0, f.dlc};
      3, 4, 5, 6: return f.data[16*(k-3) +: 16];
      default: return {3'h0, fh, 8'h00};
    endcase
  endfunction
  // one store or fetch, driven just after an edge; counts edges from taking to done
  task automatic run_op(logic is_store, logic [4:0] n);
    int cnt;
    cnt = 1;
    st_req = is_store;
    ft_req = !is_store;
    st_buf = n;
    ft_buf = n;
    @(posedge clk);
    #1;
    st_req = 1'b0;
    ft_req = 1'b0;
    chk_word("busy after take", 16'h0001, 16'(busy));
    while (done !== 1'b1 && cnt < 30) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk_word("latency", 16'h0009, 16'(cnt));
    chk_word("busy at done", 16'h0000, 16'(busy));
    // let the last word access land before the image is read
    @(posedge clk);
    #1;
  endtask
  task automatic chk_image(logic [4:0] n, int last);
    logic [15:0] a;
    for (int k = 0; k <= last; k++) begin
      a = base + 16'(8*n+k);
      chk_word("image word", img(st_frame, fhit, k), i_ram.mem[a]);
    end
  endtask
  task automatic t_store_rx();
    base = BASE;
    st_frame = f1;
    fhit = 5'h13;
    dir_sel = 1'b0;
    run_op(1'b1, 5'h03);
    chk_image(5'h03, 7);
  endtask
  task automatic t_store_tx();
    base = BASE_B;
    i_ram.mem[base + 16'd255] = 16'hbeef;
    st_frame = f2;
    fhit = 5'h1f;
    dir_sel = 1'b1;
    run_op(1'b1, 5'h1f);
    chk_image(5'h1f, 6);
    chk_word("tx word 7", 16'hbeef, i_ram.mem[base + 16'd255]);
  endtask
  task automatic t_fetch();
    base = BASE;
    run_op(1'b0, 5'h03);
    chk_frame(f1, ft_frame);
    base = BASE_B;
    i_ram.mem[base + 16'd250] = i_ram.mem[base + 16'd250] | 16'h01f0;
    run_op(1'b0, 5'h1f);
    chk_frame(f2, ft_frame);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #4000;
    bad_count++;
    print_verdict();
  end
  initial begin
    f1 = '{11'h5a5, 1'b1, 1'b1, 18'h2b3c5, 1'b1, 4'h8, 64'h8877665544332211};
    f2 = '{11'h7ff, 1'b0, 1'b0, 18'h3ffff, 1'b0, 4'hf, 64'h0123456789abcdef};
    {rst_b, st_req, ft_req, dir_sel, st_buf, ft_buf, fhit} = '0;
    base = BASE;
    st_frame = f1;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_store_rx();
    t_store_tx();
    t_fetch();
    print_verdict();
  end
endmodule
